// ===== shared/ssr_pkg.sv
// Shared constants for the serial switch register bank
package ssr_pkg;

	// Frame layout of one 16-bit serial word
	localparam int FRAME_BITS = 16;
	localparam int WR_FLAG_BIT = 15;
	localparam int WR_CMPL_BIT = 14;
	localparam int BANK_MSB = 13;
	localparam int SUB_LSB = 8;
	localparam int DATA_MSB = 7;
	localparam logic [1:0] READ_TAIL = 2'h2;
	localparam logic [1:0] READ_ANSWER_HEAD = 2'h2;

	// Bit counter width and its saturation value
	localparam int CNT_W = 5;
	localparam logic [4:0] CNT_LAST_BIT = 5'h0f;
	localparam logic [4:0] CNT_SAT = 5'h1f;

	// Register addresses as {bank_select, sub_select}
	localparam logic [5:0] ADDR_SWITCH = 6'h00;
	localparam logic [5:0] ADDR_PIN0 = 6'h04;
	localparam logic [5:0] ADDR_PIN1 = 6'h05;
	localparam logic [5:0] ADDR_IN_STATUS = 6'h06;
	localparam logic [5:0] ADDR_OL_CURRENT = 6'h08;
	localparam logic [5:0] ADDR_LOAD_SENSE = 6'h09;
	localparam logic [5:0] ADDR_HW_CONFIG = 6'h0c;
	localparam logic [5:0] ADDR_LATCH_CLEAR = 6'h0d;

	// Reset values of the writable registers
	localparam logic [7:0] SWITCH_RST = 8'h00;
	localparam logic [7:0] PIN0_RST = 8'h04;
	localparam logic [7:0] PIN1_RST = 8'h08;
	localparam logic [7:0] OL_CURRENT_RST = 8'h00;
	localparam logic RUN_MODE_RST = 1'b0;
	localparam logic [3:0] PAIR_RST = 4'h0;

	// Hardware configuration field positions
	localparam int RUN_MODE_BIT = 7;
	localparam int SOFT_RESET_BIT = 6;
	localparam int PAIR_MSB = 3;

	// Frame fault flag positions and its value after reset
	localparam int DIAG_FAULT_BIT = 10;
	localparam int STATUS_FAULT_BIT = 7;
	localparam logic FAULT_RST = 1'b1;

	// First answer after reset: input status read, fault flag set
	localparam logic [15:0] FIRST_ANSWER = 16'h8680;

endpackage : ssr_pkg

// ===== verilog/ssr_register_bank.sv
// Serial switch register bank: frame receiver, registers and answer path
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1 - Bit15 write flag, bit14 complement, address, data
// RULE2 - Switch register: one on/off bit per channel
// RULE3 - Pin0 routing; channel 2 set by default
// RULE4 - Pin1 routing; channel 3 set by default
// RULE5 - Read-only input status with frame fault flag
// RULE6 - Open-load current enable per channel, default off
// RULE7 - Read-only load sense comparison per channel
// RULE8 - Config bit7 requests run mode
// RULE9 - Config bit6 soft reset, self clearing
// RULE10 - Config bits3:0 pair neighbouring channels
// RULE11 - Config bits5:4 reserved, read zero
// RULE12 - Write-only latch clear per channel
// RULE13 - Unlisted address read returns diagnosis word
// RULE14 - Every reset restores register defaults
// RULE15 - Read ends 10; answer echoes address, data
// RULE16 - After a write, answer is diagnosis word; a soft reset write answers FIRST_ANSWER instead
// RULE17 - Writes to read-only or reserved ignored
// RULE18 - Only complete error-free frames write registers
module ssr_register_bank
	import ssr_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic SCLK,
	input wire logic CSN_N,
	input wire logic SI,
	input wire logic [1:0] IN_PIN,
	input wire logic [7:0] LOAD_SENSE,
	input wire logic [15:0] DIAG_WORD,
	output logic SO,
	output logic SO_OE,
	output logic [7:0] SWITCH_STATE,
	output logic [7:0] PIN0_ROUTING,
	output logic [7:0] PIN1_ROUTING,
	output logic [7:0] OPENLOAD_CURRENT_EN,
	output logic RUN_MODE_REQUEST,
	output logic SOFT_RESET_CMD,
	output logic [3:0] PAIRED_CHANNEL_SYNC,
	output logic [7:0] LATCH_CLEAR
);

	// Link domain: serial clock side of the frame receiver
	logic link_rst_n; // Held in reset while the frame select is idle
	logic [4:0] bit_cnt_reg; // Rising edges seen in this frame
	logic [15:0] rx_shift_reg; // Incoming bits, MSB first
	logic [15:0] rx_word_reg; // Word latched at the sixteenth edge
	logic len_ok_reg; // Exactly sixteen edges so far
	logic act_tgl_reg; // Flips on the first edge of every frame

	// Core domain: synchronisers, first stage then second stage
	logic csn_meta_reg, csn_sync_reg, csn_last_reg;
	logic sclk_meta_reg, sclk_sync_reg, sclk_last_reg;
	logic act_meta_reg, act_sync_reg;
	logic act_seen_reg; // Last activity toggle already consumed
	logic [1:0] in_meta_reg, in_sync_reg;
	logic [7:0] sense_meta_reg, sense_sync_reg;

	// Core domain: frame capture and decode
	logic csn_rise; // Frame has just closed
	logic csn_fall; // Frame has just opened
	logic sclk_fall; // Falling serial edge inside a frame
	logic frame_done_reg; // One cycle after the frame closed
	logic frame_ok_reg; // Length and activity were right
	logic [15:0] frame_word_reg; // Captured copy of the received word
	logic [5:0] frame_addr; // {bank_select, sub_select}
	logic [7:0] frame_data;
	logic frame_is_write;
	logic frame_is_read;
	logic frame_good;
	logic wr_en; // Accepted write strobe
	logic rd_en; // Accepted register read
	logic do_srst; // Soft reset request in this frame

	// Core domain: registers
	logic [7:0] switch_state_reg;
	logic [7:0] pin0_routing_reg;
	logic [7:0] pin1_routing_reg;
	logic [7:0] openload_current_enable_reg;
	logic run_mode_request_reg;
	logic [3:0] paired_channel_sync_reg;
	logic soft_reset_cmd_reg;
	logic [7:0] latch_clear_reg;
	logic frame_fault_flag_reg;

	// Core domain: answer path
	logic [7:0] rd_data; // Content of the addressed register
	logic rd_hit; // Address is a listed register
	logic [7:0] input_status_reg; // Assembled input status view
	logic [7:0] hw_config_view; // Config register as read back
	logic [15:0] diag_word; // Diagnosis word with our fault flag
	logic [15:0] tx_word_reg; // Answer for the next frame
	logic [15:0] tx_word_next;
	logic [15:0] tx_shift_reg; // Answer being shifted out
	logic so_oe_reg;

	// Idle frame select clears the counter so each frame restarts at zero
	assign link_rst_n = RESET_N & ~CSN_N;

	// Count serial edges, saturating so long frames stay recognisable
	always_ff @(posedge SCLK or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt_reg <= 5'h00;
		end else if (bit_cnt_reg != CNT_SAT) begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	// Shift in data; keep the word after the frame so the core can read it
	always_ff @(posedge SCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rx_shift_reg <= 16'h0000;
			rx_word_reg <= 16'h0000;
			len_ok_reg <= 1'b0;
			act_tgl_reg <= 1'b0;
		end else begin
			rx_shift_reg <= {rx_shift_reg[14:0], SI};
			// Any edge other than the sixteenth spoils the length
			len_ok_reg <= (bit_cnt_reg == CNT_LAST_BIT); // RULE18
			if (bit_cnt_reg == CNT_LAST_BIT) begin
				rx_word_reg <= {rx_shift_reg[14:0], SI};
			end
			// Lets the core tell an empty frame from a stale word
			if (bit_cnt_reg == 5'h00) begin
				act_tgl_reg <= ~act_tgl_reg;
			end
		end
	end

	// Bring frame select and serial clock into the core domain
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			csn_meta_reg <= 1'b1;
			csn_sync_reg <= 1'b1;
			csn_last_reg <= 1'b1;
			sclk_meta_reg <= 1'b0;
			sclk_sync_reg <= 1'b0;
			sclk_last_reg <= 1'b0;
		end else begin
			csn_meta_reg <= CSN_N;
			csn_sync_reg <= csn_meta_reg;
			csn_last_reg <= csn_sync_reg;
			sclk_meta_reg <= SCLK;
			sclk_sync_reg <= sclk_meta_reg;
			sclk_last_reg <= sclk_sync_reg;
		end
	end

	// Synchronise the activity toggle and the slow status inputs
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			act_meta_reg <= 1'b0;
			act_sync_reg <= 1'b0;
			in_meta_reg <= 2'h0;
			in_sync_reg <= 2'h0;
			sense_meta_reg <= 8'h00;
			sense_sync_reg <= 8'h00;
		end else begin
			act_meta_reg <= act_tgl_reg;
			act_sync_reg <= act_meta_reg;
			in_meta_reg <= IN_PIN;
			in_sync_reg <= in_meta_reg;
			sense_meta_reg <= LOAD_SENSE;
			sense_sync_reg <= sense_meta_reg;
		end
	end

	assign csn_rise = csn_sync_reg & ~csn_last_reg;
	assign csn_fall = ~csn_sync_reg & csn_last_reg;
	assign sclk_fall = ~csn_sync_reg & sclk_last_reg & ~sclk_sync_reg;

	// Capture the word once the frame has closed; the link side is quiet
	// by then, so the received word is stable when sampled here
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			frame_done_reg <= 1'b0;
			frame_ok_reg <= 1'b0;
			frame_word_reg <= 16'h0000;
			act_seen_reg <= 1'b0;
		end else begin
			frame_done_reg <= csn_rise;
			if (csn_rise) begin
				frame_word_reg <= rx_word_reg;
				// Good length and at least one edge in this frame
				frame_ok_reg <= len_ok_reg &
					(act_sync_reg != act_seen_reg); // RULE18
				act_seen_reg <= act_sync_reg;
			end
		end
	end

	// Decode fields of the captured frame
	assign frame_addr = frame_word_reg[BANK_MSB:SUB_LSB];
	assign frame_data = frame_word_reg[DATA_MSB:0];
	assign frame_is_write = frame_word_reg[WR_FLAG_BIT] &
		~frame_word_reg[WR_CMPL_BIT]; // RULE1
	assign frame_is_read = ~frame_word_reg[WR_FLAG_BIT] &
		frame_word_reg[WR_CMPL_BIT]; // RULE1
	// Equal flag bits are a broken frame
	assign frame_good = frame_ok_reg &
		(frame_is_write | frame_is_read); // RULE1 RULE18
	assign wr_en = frame_done_reg & frame_good & frame_is_write; // RULE18
	assign rd_en = frame_done_reg & frame_good & frame_is_read &
		(frame_word_reg[1:0] == READ_TAIL); // RULE15
	assign do_srst = wr_en & (frame_addr == ADDR_HW_CONFIG) &
		frame_data[SOFT_RESET_BIT]; // RULE9

	// Switch state; only its own address writes it
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			switch_state_reg <= SWITCH_RST; // RULE14
		end else if (do_srst) begin
			switch_state_reg <= SWITCH_RST; // RULE14
		end else if (wr_en && frame_addr == ADDR_SWITCH) begin // RULE17
			switch_state_reg <= frame_data; // RULE2
		end
	end

	// Input pin routing, one register per parallel input
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pin0_routing_reg <= PIN0_RST; // RULE3
			pin1_routing_reg <= PIN1_RST; // RULE4
		end else if (do_srst) begin
			pin0_routing_reg <= PIN0_RST; // RULE14
			pin1_routing_reg <= PIN1_RST; // RULE14
		end else if (wr_en) begin
			if (frame_addr == ADDR_PIN0) begin
				pin0_routing_reg <= frame_data; // RULE3
			end
			if (frame_addr == ADDR_PIN1) begin
				pin1_routing_reg <= frame_data; // RULE4
			end
		end
	end

	// Open-load diagnosis current enables
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			openload_current_enable_reg <= OL_CURRENT_RST; // RULE6
		end else if (do_srst) begin
			openload_current_enable_reg <= OL_CURRENT_RST; // RULE14
		end else if (wr_en && frame_addr == ADDR_OL_CURRENT) begin
			openload_current_enable_reg <= frame_data; // RULE6
		end
	end

	// Hardware configuration: run mode and pairing; reserved bits not kept
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			run_mode_request_reg <= RUN_MODE_RST;
			paired_channel_sync_reg <= PAIR_RST;
		end else if (do_srst) begin
			// Soft reset wins over the other bits of the same write
			run_mode_request_reg <= RUN_MODE_RST; // RULE9
			paired_channel_sync_reg <= PAIR_RST; // RULE14
		end else if (wr_en && frame_addr == ADDR_HW_CONFIG) begin
			run_mode_request_reg <= frame_data[RUN_MODE_BIT]; // RULE8
			paired_channel_sync_reg <= frame_data[PAIR_MSB:0]; // RULE10
		end
	end

	// One-cycle command pulses: soft reset and latch clear
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			soft_reset_cmd_reg <= 1'b0;
			latch_clear_reg <= 8'h00;
		end else begin
			// Never stored, so it reads back as zero
			soft_reset_cmd_reg <= do_srst; // RULE9
			if (wr_en && frame_addr == ADDR_LATCH_CLEAR) begin
				latch_clear_reg <= frame_data; // RULE12
			end else begin
				latch_clear_reg <= 8'h00;
			end
		end
	end

	// Frame fault flag reflects the frame just closed
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			frame_fault_flag_reg <= FAULT_RST; // RULE5
		end else if (do_srst) begin
			frame_fault_flag_reg <= FAULT_RST; // RULE14
		end else if (frame_done_reg) begin
			frame_fault_flag_reg <= ~frame_good; // RULE5
		end
	end

	// Read views of status and configuration
	assign input_status_reg = {frame_fault_flag_reg, 5'h00,
		in_sync_reg}; // RULE5
	assign hw_config_view = {run_mode_request_reg, 1'b0, 2'h0,
		paired_channel_sync_reg}; // RULE9 RULE11
	assign diag_word = {1'b0, DIAG_WORD[14:DIAG_FAULT_BIT + 1],
		~frame_good, DIAG_WORD[DIAG_FAULT_BIT - 1:0]};

	// Register read multiplexer; latch clear is write-only
	always_comb begin
		rd_data = 8'h00;
		rd_hit = 1'b1;
		unique case (frame_addr)
			ADDR_SWITCH: rd_data = switch_state_reg; // RULE2
			ADDR_PIN0: rd_data = pin0_routing_reg; // RULE3
			ADDR_PIN1: rd_data = pin1_routing_reg; // RULE4
			ADDR_IN_STATUS: rd_data = input_status_reg; // RULE5
			ADDR_OL_CURRENT: rd_data = openload_current_enable_reg;
			ADDR_LOAD_SENSE: rd_data = sense_sync_reg; // RULE7
			ADDR_HW_CONFIG: rd_data = hw_config_view; // RULE8
			default: rd_hit = 1'b0; // RULE13
		endcase
	end

	// Choose the answer for the next frame
	always_comb begin
		if (rd_en && rd_hit) begin
			tx_word_next = {READ_ANSWER_HEAD, frame_addr,
				rd_data}; // RULE15
		end else begin
			// Writes, reserved reads and broken frames
			tx_word_next = diag_word; // RULE13 RULE16
		end
	end

	// Hold the answer until the next frame opens
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tx_word_reg <= FIRST_ANSWER; // RULE14
		end else if (do_srst) begin
			tx_word_reg <= FIRST_ANSWER; // RULE14
		end else if (frame_done_reg) begin
			tx_word_reg <= tx_word_next; // RULE15 RULE16
		end
	end

	// Drive the answer MSB first, advancing on each falling serial edge;
	// the host samples on rising edges, giving half a period of margin
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tx_shift_reg <= 16'h0000;
			so_oe_reg <= 1'b0;
		end else begin
			so_oe_reg <= ~csn_sync_reg;
			if (csn_fall) begin
				tx_shift_reg <= tx_word_reg; // RULE15
			end else if (sclk_fall) begin
				tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
			end
		end
	end

	// Outputs straight from flops
	assign SO = tx_shift_reg[FRAME_BITS - 1];
	assign SO_OE = so_oe_reg;
	assign SWITCH_STATE = switch_state_reg;
	assign PIN0_ROUTING = pin0_routing_reg;
	assign PIN1_ROUTING = pin1_routing_reg;
	assign OPENLOAD_CURRENT_EN = openload_current_enable_reg;
	assign RUN_MODE_REQUEST = run_mode_request_reg;
	assign SOFT_RESET_CMD = soft_reset_cmd_reg;
	assign PAIRED_CHANNEL_SYNC = paired_channel_sync_reg;
	assign LATCH_CLEAR = latch_clear_reg;

endmodule // ssr_register_bank

`default_nettype wire

// ===== testbench/ssr_host_model.sv
// Serial host model: drives frames on the link and captures replies
`timescale 1ns/1ps
`default_nettype none
module ssr_host_model (
	output logic sclk,
	output logic csn_n,
	output logic si,
	input wire logic so
);
	// Idle: clock parked low, frame closed
	initial begin
		sclk = 1'b0;
		csn_n = 1'b1;
		si = 1'b0;
	end

	// One frame of n rising edges, MSB first; reply sampled on rising edge
	task automatic frame(input logic [15:0] w, input int n,
		output logic [15:0] r);
		r = 16'h0000;
		// Odd offset keeps the link unrelated in phase to the core clock
		#3.3 csn_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			si = (i < 16) ? w[15 - i] : 1'b0;
			#80 sclk = 1'b1;
			if (i < 16) begin
				r[15 - i] = so;
			end
			#80 sclk = 1'b0;
		end
		#80 csn_n = 1'b1;
		// Released data line shows the inverse, never a held value
		si = ~si;
		// Long gap so the answer is ready before the next frame
		#200;
	endtask
endmodule // ssr_host_model
`default_nettype wire

// ===== testbench/ssr_bank_assertions.sv
// Concurrent checks on the register bank's top ports
`timescale 1ns/1ps
`default_nettype none
module ssr_bank_assertions
	import ssr_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic SCLK,
	input wire logic CSN_N,
	input wire logic SO,
	input wire logic SO_OE,
	input wire logic [7:0] SWITCH_STATE,
	input wire logic [7:0] PIN0_ROUTING,
	input wire logic [7:0] PIN1_ROUTING,
	input wire logic [7:0] OPENLOAD_CURRENT_EN,
	input wire logic RUN_MODE_REQUEST,
	input wire logic SOFT_RESET_CMD,
	input wire logic [3:0] PAIRED_CHANNEL_SYNC,
	input wire logic [7:0] LATCH_CLEAR
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);

	// All host-programmable state in one vector
	logic [36:0] regs;
	assign regs = {SWITCH_STATE, PIN0_ROUTING, PIN1_ROUTING,
		OPENLOAD_CURRENT_EN, RUN_MODE_REQUEST, PAIRED_CHANNEL_SYNC};

	// Frame held open, frame held closed, link clock held high
	sequence sel_held;
		!CSN_N [*5];
	endsequence
	sequence idle_held;
		CSN_N [*5];
	endsequence
	sequence sclk_high;
		SCLK [*3];
	endsequence

	reg_hold_a: assert property ($changed(regs) |->
		$past(CSN_N, 1) && $past(CSN_N, 2))
		else $error("register output moved inside a frame");
	soft_pulse_a: assert property (SOFT_RESET_CMD |=> !SOFT_RESET_CMD)
		else $error("soft reset pulse longer than one cycle");
	soft_defaults_a: assert property ($rose(SOFT_RESET_CMD) |->
		regs == {SWITCH_RST, PIN0_RST, PIN1_RST, OL_CURRENT_RST,
		RUN_MODE_RST, PAIR_RST})
		else $error("soft reset left registers off default");
	soft_after_frame_a: assert property ($rose(SOFT_RESET_CMD) |->
		$past(CSN_N, 2) && $past(CSN_N, 3))
		else $error("soft reset without a closed frame");
	clear_pulse_a: assert property ((LATCH_CLEAR != 8'h00) |=>
		(LATCH_CLEAR == 8'h00))
		else $error("latch clear pulse longer than one cycle");
	oe_frame_a: assert property (sel_held |-> SO_OE)
		else $error("data out not enabled in a frame");
	oe_idle_a: assert property (idle_held |-> !SO_OE)
		else $error("data out enabled while idle");
	so_steady_a: assert property (sclk_high |-> $stable(SO))
		else $error("data out moved while link clock high");
endmodule // ssr_bank_assertions
`default_nettype wire

// ===== testbench/ssr_register_bank_tb.sv
// Self-checking bench for the serial switch register bank
`timescale 1ns/1ps
`default_nettype none
module ssr_register_bank_tb;
	import ssr_pkg::*;
	logic clk, reset_n, sclk, csn_n, si, so, so_oe, run, srst;
	logic [1:0] in_pin;
	logic [7:0] load_sense, sw, p0, p1, ol, lclr, s_sw, s_p0, s_p1, s_ol;
	logic [15:0] diag_word, pend, w;
	logic [3:0] pair, s_pair;
	logic s_run; // Shadow of the run request bit
	logic s_fault; // Shadow of the frame fault flag
	logic [8:0] s_pulse; // Pulse owed: {soft reset, latch clear}
	logic [8:0] pulse_last; // Last pulse seen: {soft reset, latch clear}
	int pulse_cnt = 0; // Command pulses seen so far
	wire so_line; // Data out pin, floating while not driven
	int miscompares = 0;
	int check_count = 0;
	int seed = 32'ha3ed;
	// Hand-picked frames: every register, read-only, reserved, bad flags
	logic [15:0] corner [24] = '{16'h80a5, 16'h4002, 16'h84ff, 16'h4402,
		16'h8500, 16'h4502, 16'h8833, 16'h4802, 16'h4602, 16'h4902,
		16'h8cbf, 16'h4c02, 16'h8d5a, 16'h4d02, 16'h86ff, 16'h89ff,
		16'hbf12, 16'h4002, 16'h7f02, 16'h4003, 16'hc002, 16'h0002,
		16'h8cc3, 16'h4c02};
	int lens [4] = '{0, 8, 15, 17}; // Refused frame lengths

	assign so_line = so_oe ? so : 1'bz;
	always #5 clk = ~clk;

	ssr_register_bank ssr_register_bank_i (.CLK(clk), .RESET_N(reset_n),
		.SCLK(sclk), .CSN_N(csn_n), .SI(si), .IN_PIN(in_pin),
		.LOAD_SENSE(load_sense), .DIAG_WORD(diag_word), .SO(so),
		.SO_OE(so_oe), .SWITCH_STATE(sw), .PIN0_ROUTING(p0),
		.PIN1_ROUTING(p1), .OPENLOAD_CURRENT_EN(ol),
		.RUN_MODE_REQUEST(run), .SOFT_RESET_CMD(srst),
		.PAIRED_CHANNEL_SYNC(pair), .LATCH_CLEAR(lclr));
	ssr_host_model ssr_host_model_i (.sclk(sclk), .csn_n(csn_n), .si(si),
		.so(so_line));

	// Shadow registers back to their defaults
	function automatic void defaults();
		s_sw = SWITCH_RST;
		s_p0 = PIN0_RST;
		s_p1 = PIN1_RST;
		s_ol = OL_CURRENT_RST;
		s_run = RUN_MODE_RST;
		s_pair = PAIR_RST;
		s_fault = FAULT_RST;
	endfunction

	// Count command pulses at the falling edge, where they have settled
	always @(negedge clk) begin
		if (srst || lclr != 8'h00) begin
			pulse_cnt++;
			pulse_last = {srst, lclr};
		end
	end

	// Diagnosis word as the device answers it
	function automatic logic [15:0] diag(input logic f);
		return {1'b0, diag_word[14:11], f, diag_word[9:0]};
	endfunction

	// Answer owed for a frame, updating the shadows on writes
	function automatic logic [15:0] predict(input logic [15:0] f,
		input int n);
		logic [5:0] a;
		logic pf;
		a = f[13:8];
		// Status read shows the flag left by the frame before it
		pf = s_fault;
		s_fault = (n != 16 || f[15] == f[14]);
		s_pulse = 9'h000;
		if (n != 16 || f[15] == f[14]) begin
			return diag(1'b1);
		end
		if (f[15]) begin
			case (a)
				ADDR_SWITCH: s_sw = f[7:0];
				ADDR_PIN0: s_p0 = f[7:0];
				ADDR_PIN1: s_p1 = f[7:0];
				ADDR_OL_CURRENT: s_ol = f[7:0];
				ADDR_LATCH_CLEAR: s_pulse = {1'b0, f[7:0]};
				ADDR_HW_CONFIG: begin
					if (f[SOFT_RESET_BIT]) begin
						s_pulse = 9'h100;
						defaults();
						return FIRST_ANSWER;
					end
					s_run = f[RUN_MODE_BIT];
					s_pair = f[PAIR_MSB:0];
				end
				default: ;
			endcase
			return diag(1'b0);
		end
		if (f[1:0] != READ_TAIL) begin
			return diag(1'b0);
		end
		case (a)
			ADDR_SWITCH: return {READ_ANSWER_HEAD, a, s_sw};
			ADDR_PIN0: return {READ_ANSWER_HEAD, a, s_p0};
			ADDR_PIN1: return {READ_ANSWER_HEAD, a, s_p1};
			ADDR_OL_CURRENT: return {READ_ANSWER_HEAD, a, s_ol};
			ADDR_IN_STATUS: return {READ_ANSWER_HEAD, a, pf, 5'h00,
				in_pin};
			ADDR_LOAD_SENSE: return {READ_ANSWER_HEAD, a, load_sense};
			ADDR_HW_CONFIG: return {READ_ANSWER_HEAD, a, s_run, 3'h0, s_pair};
			default: return diag(1'b0);
		endcase
	endfunction

	// Compare and count
	task automatic check(input string name, input logic [63:0] seen,
		input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One frame with fresh random levels; checks reply and outputs
	task automatic xfer(input logic [15:0] f, input int n);
		logic [15:0] r;
		logic [15:0] m;
		int c0;
		@(negedge clk);
		c0 = pulse_cnt;
		// A short frame only shifts out its leading answer bits
		m = ~(16'hffff >> n);
		in_pin = 2'($random(seed));
		load_sense = 8'($random(seed));
		diag_word = 16'($random(seed));
		ssr_host_model_i.frame(f, n, r);
		check("answer", r & m, pend & m);
		pend = predict(f, n);
		check("outputs", {sw, p0, p1, ol, run, pair},
			{s_sw, s_p0, s_p1, s_ol, s_run, s_pair});
		check("pulse count", pulse_cnt - c0,
			(s_pulse != 9'h000) ? 1 : 0);
		if (s_pulse != 9'h000) begin
			check("pulse value", pulse_last, s_pulse);
		end
	endtask

	// Verdict in one place
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Watchdog: the run needs about 250 us, so 600 us means a hang
	initial begin
		#600000;
		miscompares++;
		stop_test();
	end

	// Main sequence
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		in_pin = 2'h0;
		load_sense = 8'h00;
		diag_word = 16'h0000;
		defaults();
		pend = FIRST_ANSWER;
		repeat (6) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		repeat (3) @(posedge clk);
		check("reset", {sw, p0, p1, ol, run, pair, srst, lclr, so_oe},
			{s_sw, s_p0, s_p1, s_ol, s_run, s_pair, 10'h000});
		$display("test reset done");
		foreach (corner[i]) begin
			xfer(corner[i], 16);
		end
		$display("test corners done");
		foreach (lens[j]) begin
			xfer(16'h80ff, lens[j]);
		end
		$display("test lengths done");
		for (int k = 0; k < 60; k++) begin
			w = 16'($random(seed));
			w[14] = ~w[15];
			w[13:12] = 2'h0;
			if (!w[15] && w[2]) begin
				w[1:0] = READ_TAIL;
			end
			xfer(w, (w[5:3] == 3'h0) ? 15 : 16);
		end
		xfer(16'h4602, 16);
		$display("test random done");
		stop_test();
	end
endmodule // ssr_register_bank_tb

bind ssr_register_bank ssr_bank_assertions ssr_bank_assertions_i (
	.CLK(CLK), .RESET_N(RESET_N), .SCLK(SCLK), .CSN_N(CSN_N), .SO(SO),
	.SO_OE(SO_OE), .SWITCH_STATE(SWITCH_STATE),
	.PIN0_ROUTING(PIN0_ROUTING), .PIN1_ROUTING(PIN1_ROUTING),
	.OPENLOAD_CURRENT_EN(OPENLOAD_CURRENT_EN),
	.RUN_MODE_REQUEST(RUN_MODE_REQUEST), .SOFT_RESET_CMD(SOFT_RESET_CMD),
	.PAIRED_CHANNEL_SYNC(PAIRED_CHANNEL_SYNC), .LATCH_CLEAR(LATCH_CLEAR));
`default_nettype wire
